/* design/lec_classifier.sv */
// link error status classifier: sorts error events into device status classes
//
// The implementer's own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/100ps
module lec_classifier import lec_pkg::*; (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic [16:0] EVENT_IN,
  input wire logic EVENT_FROM_TX,
  input wire logic RX_REQ_VALID,
  input wire logic [31:0] RX_REQ_ADDR,
  input wire logic TX_PKT_SENT,
  input wire logic ACK_RCVD,
  input wire logic TX_REQ_SENT,
  input wire logic CPL_RCVD,
  input wire logic [3:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA,
  output logic [3:0] DEVICE_STATUS_OUT,
  output logic MSG_VALID,
  output logic [1:0] MSG_CODE,
  output logic REPLAY_REQ,
  output logic IRQ
);

  // register map on the plain port, one word per offset:
  //   status  write one to clear; a set in the same cycle wins over the clear
  //   mask    interrupt mask, same layout as status
  //   ctrl    per-class message enables; UR messages need their own enable too
  //   events  per-event sticky copy, write one to clear
  //   bar0    base and size of the single decoded receive window
  //   limits  completion and ack wait spans, in clock cycles
  // software-visible registers
  logic [3:0] status_reg;
  logic [3:0] mask_reg;
  logic [3:0] ctrl_reg;
  logic [16:0] events_reg;
  logic [31:0] bar0_reg;
  logic [31:0] bar0_size_reg;
  logic [31:0] cpl_limit_reg;
  logic [31:0] replay_limit_reg;
  // timer state, one outstanding item per timer
  logic [31:0] cpl_cnt_reg;
  logic cpl_wait_reg;
  logic [31:0] replay_cnt_reg;
  logic replay_wait_reg;
  logic cpl_to_pulse;
  logic replay_to_pulse;
  // combinational decode
  logic bar_miss;
  logic [16:0] ev;
  logic [3:0] set_vec;
  logic wr_status;
  logic wr_events;
  logic cpl_expire;
  logic replay_expire;

  // true when the address falls inside the window
  function automatic logic in_window(input logic [31:0] a, input logic [31:0] base,
                                     input logic [31:0] size);
    in_window = (a >= base) && ((a - base) < size);
  endfunction

  // true when any event of one class mask is present
  function automatic logic any_in(input logic [16:0] v, input logic [16:0] m);
    any_in = |(v & m);
  endfunction

  // narrow register placed in the low bits of a read word
  function automatic logic [31:0] low_bits(input logic [3:0] v);
    low_bits = {28'h0000000, v};
  endfunction

  // one step of a wait counter
  function automatic logic [31:0] step_count(input logic [31:0] c);
    step_count = c + 32'h00000001;
  endfunction

  // a wait counter has run its span once it reaches the limit; a limit of
  // zero therefore fires on the first cycle of waiting
  function automatic logic span_done(input logic [31:0] c, input logic [31:0] lim);
    span_done = (c >= lim);
  endfunction

  // write strobe aimed at one offset of the register port
  function automatic logic wr_hit(input logic strobe, input logic [3:0] at,
                                  input logic [3:0] target);
    wr_hit = strobe && (at == target);
  endfunction

  // write decode shared by the two write-one-to-clear registers
  assign wr_status = wr_hit(REG_WR, REG_ADDR, A_STATUS);
  assign wr_events = wr_hit(REG_WR, REG_ADDR, A_EVENTS);

  // both timers use the same end-point rule
  assign cpl_expire = span_done(cpl_cnt_reg, cpl_limit_reg);
  assign replay_expire = span_done(replay_cnt_reg, replay_limit_reg);

  assign bar_miss = RX_REQ_VALID && !in_window(RX_REQ_ADDR, bar0_reg, bar0_size_reg);

  // merged event vector; own-transmit events ignored
  always_comb begin
    ev = '0;
    if (!EVENT_FROM_TX) begin
      ev = EVENT_IN;
    end
    // replay and completion timers are our own detections
    ev[EV_REPLAY_TO] = ev[EV_REPLAY_TO] | replay_to_pulse;
    ev[EV_CPL_TO] = ev[EV_CPL_TO] | cpl_to_pulse;
    // a window miss needs no event pin; it is found from the address
    ev[EV_UR] = ev[EV_UR] | bar_miss;
  end

  // class decode
  always_comb begin
    set_vec = '0;
    set_vec[DS_CORR] = any_in(ev, CORR_MASK);
    set_vec[DS_NONFATAL] = any_in(ev, NONFATAL_MASK);
    set_vec[DS_FATAL] = any_in(ev, FATAL_MASK);
    set_vec[DS_UR] = ev[EV_UR];
  end

  // status: set beats a write-one clear in the same cycle
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      status_reg <= '0;
    end else begin
      // only the low write data bits clear; upper bits are ignored
      // sticky until written one
      if (wr_status) begin
        status_reg <= (status_reg & ~REG_WDATA[3:0]) | set_vec;
      end else begin
        status_reg <= status_reg | set_vec;
      end
    end
  end

  // per-event sticky capture for software diagnosis
  // timer detections land here too, so software can tell them apart
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      events_reg <= '0;
    end else if (wr_events) begin
      events_reg <= (events_reg & ~REG_WDATA[16:0]) | ev;
    end else begin
      events_reg <= events_reg | ev;
    end
  end

  // software-written configuration registers
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      mask_reg <= '0;
      ctrl_reg <= '0;
      bar0_reg <= '0;
      bar0_size_reg <= BAR_SIZE_RST;
      cpl_limit_reg <= CPL_LIMIT_RST;
      replay_limit_reg <= REPLAY_LIMIT_RST;
    end else if (REG_WR) begin
      unique case (REG_ADDR)
        A_MASK: mask_reg <= REG_WDATA[3:0];
        A_CTRL: ctrl_reg <= REG_WDATA[3:0];
        A_BAR0: bar0_reg <= REG_WDATA;
        A_BAR0_SIZE: bar0_size_reg <= REG_WDATA;
        A_CPL_LIMIT: cpl_limit_reg <= REG_WDATA;
        A_REPLAY_LIMIT: replay_limit_reg <= REG_WDATA;
        // unmapped offsets are ignored on write
        default: ;
      endcase
    end
  end

  // read data one cycle after the strobe, zero otherwise
  // the port is cleared between reads so a stale word never lingers
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      REG_RDATA <= '0;
    end else if (REG_RD) begin
      unique case (REG_ADDR)
        A_STATUS: REG_RDATA <= low_bits(status_reg);
        A_MASK: REG_RDATA <= low_bits(mask_reg);
        A_CTRL: REG_RDATA <= low_bits(ctrl_reg);
        A_EVENTS: REG_RDATA <= {15'h0000, events_reg};
        A_BAR0: REG_RDATA <= bar0_reg;
        A_BAR0_SIZE: REG_RDATA <= bar0_size_reg;
        A_CPL_LIMIT: REG_RDATA <= cpl_limit_reg;
        A_REPLAY_LIMIT: REG_RDATA <= replay_limit_reg;
        default: REG_RDATA <= '0;
      endcase
    end else begin
      REG_RDATA <= '0;
    end
  end

  // completion timer; one outstanding request tracked
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      cpl_wait_reg <= 1'b0;
      cpl_cnt_reg <= '0;
      cpl_to_pulse <= 1'b0;
    end else begin
      cpl_to_pulse <= 1'b0;
      // a completion beats a new request in the same cycle; that request goes untimed
      // the count holds while idle and restarts with the next request
      if (CPL_RCVD) begin
        cpl_wait_reg <= 1'b0;
      end else if (TX_REQ_SENT) begin
        cpl_wait_reg <= 1'b1;
        cpl_cnt_reg <= '0;
      end else if (cpl_wait_reg) begin
        if (cpl_expire) begin
          cpl_wait_reg <= 1'b0;
          cpl_to_pulse <= 1'b1;
        end else begin
          cpl_cnt_reg <= step_count(cpl_cnt_reg);
        end
      end
    end
  end

  // ack timer; expiry asks for replay and restarts
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      replay_wait_reg <= 1'b0;
      replay_cnt_reg <= '0;
      replay_to_pulse <= 1'b0;
      REPLAY_REQ <= 1'b0;
    end else begin
      replay_to_pulse <= 1'b0;
      REPLAY_REQ <= 1'b0;
      // packets sent while already waiting share the running timer
      if (ACK_RCVD) begin
        replay_wait_reg <= 1'b0;
      end else if (TX_PKT_SENT && !replay_wait_reg) begin
        replay_wait_reg <= 1'b1;
        replay_cnt_reg <= '0;
      end else if (replay_wait_reg) begin
        // restart after expiry so a silent partner keeps being retried
        // resend unacknowledged packet
        if (replay_expire) begin
          replay_cnt_reg <= '0;
          replay_to_pulse <= 1'b1;
          REPLAY_REQ <= 1'b1;
        end else begin
          replay_cnt_reg <= step_count(replay_cnt_reg);
        end
      end
    end
  end

  // upstream message, worst class wins when several fire at once
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      MSG_VALID <= 1'b0;
      MSG_CODE <= MSG_CORR;
    end else begin
      MSG_VALID <= 1'b0;
      // UR needs the non-fatal and the UR enable before it may message
      // the code holds its last value between messages
      // gated by class enables
      if (set_vec[DS_FATAL] && ctrl_reg[C_EN_FATAL]) begin
        MSG_VALID <= 1'b1;
        MSG_CODE <= MSG_FATAL;
      end else if (set_vec[DS_NONFATAL] && ctrl_reg[C_EN_NONFATAL] &&
                   (!ev[EV_UR] || ctrl_reg[C_EN_UR])) begin
        MSG_VALID <= 1'b1;
        MSG_CODE <= MSG_NONFATAL;
      end else if (set_vec[DS_CORR] && ctrl_reg[C_EN_CORR]) begin
        MSG_VALID <= 1'b1;
        MSG_CODE <= MSG_CORR;
      end
    end
  end

  // status leaves through one more flop so every output comes from a register
  // the interrupt trails the status bits by that same cycle
  // status and interrupt outputs
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      DEVICE_STATUS_OUT <= '0;
      IRQ <= 1'b0;
    end else begin
      DEVICE_STATUS_OUT <= status_reg;
      IRQ <= |(status_reg & mask_reg);
    end
  end

endmodule

/* design/lec_pkg.sv */
// package of constants for the link error status classifier
package lec_pkg;
  // device status bit positions
  localparam int DS_CORR = 0;
  localparam int DS_NONFATAL = 1;
  localparam int DS_FATAL = 2;
  localparam int DS_UR = 3;
  localparam int DS_W = 4;
  // event vector bit positions
  localparam int EV_TRAIN = 0;
  localparam int EV_DLLPROT = 1;
  localparam int EV_FCPROT = 2;
  localparam int EV_MALFORMED = 3;
  localparam int EV_RXOVF = 4;
  localparam int EV_RXERR = 5;
  localparam int EV_BADPKT = 6;
  localparam int EV_BADLINK = 7;
  localparam int EV_REPLAY_TO = 8;
  localparam int EV_REPLAY_ROLL = 9;
  localparam int EV_POISON = 10;
  localparam int EV_ECRC = 11;
  localparam int EV_UR = 12;
  localparam int EV_CPL_TO = 13;
  localparam int EV_CPL_ABORT = 14;
  localparam int EV_UNEXP_CPL = 15;
  localparam int EV_ACS = 16;
  localparam int EV_W = 17;
  // class masks over the event vector
  localparam logic [16:0] FATAL_MASK = 17'h0001F;
  localparam logic [16:0] CORR_MASK = 17'h003E0;
  localparam logic [16:0] NONFATAL_MASK = 17'h1FC00;
  // register offsets of the plain register port
  localparam logic [3:0] A_STATUS = 4'h0;
  localparam logic [3:0] A_MASK = 4'h1;
  localparam logic [3:0] A_CTRL = 4'h2;
  localparam logic [3:0] A_EVENTS = 4'h3;
  localparam logic [3:0] A_BAR0 = 4'h4;
  localparam logic [3:0] A_BAR0_SIZE = 4'h5;
  localparam logic [3:0] A_CPL_LIMIT = 4'h6;
  localparam logic [3:0] A_REPLAY_LIMIT = 4'h7;
  // control bits: reporting enables per class
  localparam int C_EN_CORR = 0;
  localparam int C_EN_NONFATAL = 1;
  localparam int C_EN_FATAL = 2;
  localparam int C_EN_UR = 3;
  // reset values
  localparam logic [31:0] CPL_LIMIT_RST = 32'h00000400;
  localparam logic [31:0] REPLAY_LIMIT_RST = 32'h00000040;
  localparam logic [31:0] BAR_SIZE_RST = 32'h00001000;
  // message codes sent upstream
  localparam logic [1:0] MSG_CORR = 2'h0;
  localparam logic [1:0] MSG_NONFATAL = 2'h1;
  localparam logic [1:0] MSG_FATAL = 2'h2;
endpackage

/* dv/lec_chk_sva.sv */
// port checks for the classifier
`timescale 1ns/100ps
module lec_chk_sva import lec_pkg::*; (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic [16:0] EVENT_IN,
  input wire logic EVENT_FROM_TX,
  input wire logic [3:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic [3:0] DEVICE_STATUS_OUT,
  input wire logic MSG_VALID,
  input wire logic [1:0] MSG_CODE,
  input wire logic REPLAY_REQ
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  logic ok, fat, clr;
  // own-transmit events never count
  assign ok = !EVENT_FROM_TX;
  assign fat = ok && |(EVENT_IN & FATAL_MASK);
  assign clr = REG_WR && REG_ADDR == A_STATUS && REG_WDATA[DS_FATAL];
  a_fatal_sets: assert property (fat |-> ##2 DEVICE_STATUS_OUT[DS_FATAL])
    else $error("fatal event lost");
  a_corr_sets: assert property (ok && |(EVENT_IN & CORR_MASK) |->
    ##2 DEVICE_STATUS_OUT[DS_CORR]) else $error("correctable event lost");
  a_nonfatal_sets: assert property (ok && |(EVENT_IN & NONFATAL_MASK) |->
    ##2 DEVICE_STATUS_OUT[DS_NONFATAL]) else $error("non-fatal event lost");
  a_ur_pair: assert property (ok && EVENT_IN[EV_UR] |->
    ##2 DEVICE_STATUS_OUT[DS_UR] && DEVICE_STATUS_OUT[DS_NONFATAL]) else $error("ur pair");
  a_fatal_cause: assert property ($rose(DEVICE_STATUS_OUT[DS_FATAL]) |-> $past(fat, 2))
    else $error("fatal bit without cause");
  a_sticky_clear: assert property ($fell(DEVICE_STATUS_OUT[DS_FATAL]) |-> $past(clr, 2))
    else $error("fatal bit dropped");
  a_fatal_msg: assert property (MSG_VALID && MSG_CODE == MSG_FATAL |-> $past(fat))
    else $error("fatal message without cause");
  a_replay_corr: assert property (REPLAY_REQ |-> ##[1:3] DEVICE_STATUS_OUT[DS_CORR])
    else $error("replay not flagged");
  c_fatal: cover property (fat ##1 MSG_VALID);
  c_replay: cover property (REPLAY_REQ);
  c_clear: cover property ($fell(DEVICE_STATUS_OUT[DS_FATAL]));
endmodule
bind lec_classifier lec_chk_sva u_chk (.*);

/* dv/lec_link_model.sv */
// link partner stand-in: acks packets, returns completions
`timescale 1ns/100ps
module lec_link_model (
  input wire logic clk,
  input wire logic mute,
  input wire logic pkt,
  input wire logic req,
  output logic ack,
  output logic cpl
);
  logic [1:0] pd = 2'h0, qd = 2'h0;
  // answer two cycles late; mute models a hung partner
  always @(posedge clk) begin
    pd <= {pd[0], pkt & !mute};
    qd <= {qd[0], req & !mute};
  end
  assign ack = pd[1];
  assign cpl = qd[1];
endmodule

/* dv/tb_top.sv */
// self-checking bench for the classifier
`timescale 1ns/100ps
module tb_top import lec_pkg::*; ;
  logic clk = 1'b0, rst_n = 1'b0, ftx = 1'b0, rqv = 1'b0, pkt = 1'b0, req = 1'b0;
  logic wr = 1'b0, rd = 1'b0, mute = 1'b0, ack, cpl, mv, rp, irq, ms, is, seen;
  logic [16:0] ev = '0;
  logic [31:0] rqa = '0, wd = '0, rdat;
  logic [3:0] ra = '0, dso, ds, cls;
  logic [1:0] mc, cs, code;
  int errors = 0, num_checks = 0;
  lec_classifier dut (.CLK(clk), .RST_N(rst_n), .EVENT_IN(ev), .EVENT_FROM_TX(ftx),
    .RX_REQ_VALID(rqv), .RX_REQ_ADDR(rqa), .TX_PKT_SENT(pkt), .ACK_RCVD(ack),
    .TX_REQ_SENT(req), .CPL_RCVD(cpl), .REG_ADDR(ra), .REG_WDATA(wd), .REG_WR(wr),
    .REG_RD(rd), .REG_RDATA(rdat), .DEVICE_STATUS_OUT(dso), .MSG_VALID(mv),
    .MSG_CODE(mc), .REPLAY_REQ(rp), .IRQ(irq));
  lec_link_model peer (.clk(clk), .mute(mute), .pkt(pkt), .req(req), .ack(ack), .cpl(cpl));
  // 100 ns period
  initial forever #50 clk = !clk;
  task automatic wrap_up;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, exp, got);
    end
  endtask
  // strobes drop a full cycle before the next access, never re-driven in one step
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    {ra, wd, wr} <= {a, d, 1'b1};
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
    {ra, rd} <= {a, 1'b1};
    @(posedge clk);
    rd <= 1'b0;
    #1 chk("rdata", rdat, e);
    @(posedge clk);
  endtask
  // message shows one cycle after the event, status and irq one later
  task automatic stim(input logic [16:0] v, input logic t, input logic q, input logic [31:0] a);
    {ev, ftx, rqv, rqa} <= {v, t, q, a};
    @(posedge clk);
    {ev, ftx, rqv} <= '0;
    #1 {ms, cs} = {mv, mc};
    @(posedge clk);
    #1 {ds, is} = {dso, irq};
    @(posedge clk);
  endtask
  // fixed window: absence of a replay cannot be awaited any other way
  task automatic link(input logic p, input logic m);
    // each pulse is one well-formed packet
    // a single read in flight, so completions fit
    {mute, pkt, req} <= {m, p, !p};
    @(posedge clk);
    {pkt, req} <= 2'h0;
    seen = 1'b0;
    repeat (12) begin
      @(posedge clk);
      #1 seen |= rp;
    end
    ds = dso;
    @(posedge clk);
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1 chk("status", 32'(dso), 0);
    @(posedge clk);
    rd_chk(A_MASK, 0);
    rd_chk(A_CTRL, 0);
    rd_chk(A_BAR0_SIZE, BAR_SIZE_RST);
    rd_chk(A_CPL_LIMIT, CPL_LIMIT_RST);
    rd_chk(A_REPLAY_LIMIT, REPLAY_LIMIT_RST);
    rd_chk(4'hF, 0);
    wr_reg(A_CTRL, 32'h7);
    wr_reg(A_MASK, 32'h4);
    wr_reg(A_CPL_LIMIT, 32'h4);
    wr_reg(A_REPLAY_LIMIT, 32'h4);
    wr_reg(A_BAR0, 32'h1000);
    // every event code once; ur message held back by its enable
    for (int i = 0; i < EV_W; i++) begin
      cls = FATAL_MASK[i] ? 4'h4 : (CORR_MASK[i] ? 4'h1 : 4'h2);
      code = FATAL_MASK[i] ? MSG_FATAL : (CORR_MASK[i] ? MSG_CORR : MSG_NONFATAL);
      if (i == EV_UR) cls = 4'hA;
      stim(17'h1 << i, 1'b0, 1'b0, 0);
      chk("status", 32'(ds), 32'(cls));
      chk("msg", 32'(ms), 32'(i != EV_UR));
      if (i != EV_UR) chk("code", 32'(cs), 32'(code));
      chk("irq", 32'(is), 32'(cls[DS_FATAL]));
      rd_chk(A_STATUS, 32'(cls));
      rd_chk(A_EVENTS, 32'(17'h1 << i));
      wr_reg(A_STATUS, 32'hF);
      wr_reg(A_EVENTS, 32'h1FFFF);
    end
    stim(FATAL_MASK, 1'b1, 1'b0, 0);
    chk("tx status", 32'(ds), 0);
    chk("tx msg", 32'(ms), 0);
    wr_reg(A_CTRL, 0);
    stim(FATAL_MASK, 1'b0, 1'b0, 0);
    chk("quiet msg", 32'(ms), 0);
    chk("quiet status", 32'(ds), 32'h4);
    wr_reg(A_STATUS, 32'hF);
    stim(0, 1'b0, 1'b1, 32'h1FFF);
    chk("in window", 32'(ds), 0);
    stim(0, 1'b0, 1'b1, 32'h2000);
    chk("past window", 32'(ds), 32'hA);
    wr_reg(A_STATUS, 32'hF);
    link(1'b0, 1'b0);
    chk("cpl ok", 32'(ds), 0);
    link(1'b0, 1'b1);
    chk("cpl lost", 32'(ds), 32'h2);
    wr_reg(A_STATUS, 32'hF);
    link(1'b1, 1'b0);
    chk("acked", 32'({seen, ds}), 0);
    link(1'b1, 1'b1);
    chk("replayed", 32'({seen, ds}), 32'h11);
    wrap_up();
  end
  // hang guard, well past the few hundred cycles the tests take
  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    wrap_up();
  end
endmodule
